// File: design/swk_ctrl.sv
// sleep wake-up controller: sleep instruction handling, status bits, apb registers
// assumes the core pulses sleep_req_i once per sleep instruction while running,
// and interrupt enables and flags arrive from peripheral logic on mclk_i
`timescale 1ns/1ns
module swk_ctrl
  import swk_pkg::*;
#(
  parameter int N_SRC = 8
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [SWK_AW-1:0] paddr_i,
  input wire logic [SWK_DW-1:0] pwdata_i,
  output logic [SWK_DW-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic sleep_req_i,
  input wire logic [N_SRC-1:0] int_en_i,
  input wire logic [N_SRC-1:0] int_flag_i,
  output logic sleep_o,
  output logic wdt_clear_o,
  output logic wake_o,
  output logic vector_o,
  output logic resume_o,
  output logic nop_o,
  output logic irq_o
);
  localparam logic [2:0] LAST = 3'(SWK_INSN_CYC - 1);

  swk_core_t r;
  swk_core_t next_r;
  logic pend;
  logic [N_SRC-1:0] hit;
  logic [SWK_EV_W-1:0] ev;
  logic [SWK_EV_W-1:0] istat;
  logic [SWK_EV_W-1:0] ien;
  logic acc;
  logic wr;
  logic wr_ctrl;
  logic wr_clr;
  logic wr_en;
  logic [SWK_DW-1:0] rdata;
  logic unmapped;

  swk_pend #(
    .N(N_SRC)
  ) u_pend (
    .int_en_i(int_en_i),
    .int_flag_i(int_flag_i),
    .hit_o(hit),
    .pend_o(pend)
  );

  swk_irq #(
    .W(SWK_EV_W)
  ) u_irq (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .set_i(ev),
    .clr_wr_i(wr_clr),
    .en_wr_i(wr_en),
    .wdata_i(pwdata_i[SWK_EV_W-1:0]),
    .stat_o(istat),
    .en_o(ien),
    .irq_o(irq_o)
  );

  // zero wait states: every access completes in its first access cycle
  assign acc = psel_i & penable_i;
  assign wr = acc & pwrite_i;
  assign wr_ctrl = wr & (paddr_i == SWK_OFF_CTRL);
  assign wr_clr = wr & (paddr_i == SWK_OFF_INT_CLR);
  assign wr_en = wr & (paddr_i == SWK_OFF_INT_EN);

  always_comb begin
    next_r = r;
    ev = '0;
    next_r.wdt_clr = 1'b0;
    next_r.wake = 1'b0;
    next_r.vec = 1'b0;
    next_r.res = 1'b0;
    next_r.nop = 1'b0;
    if (wr_ctrl) begin
      next_r.global_interrupt_enable = pwdata_i[SWK_CTRL_GIE_BIT];
      // rearm only sets; a sleep completing in the same cycle overrides below
      if (pwdata_i[SWK_CTRL_REARM_BIT]) begin
        next_r.to = 1'b1;
        next_r.pd = 1'b1;
      end
    end
    case (r.st)
      SWK_RUN: begin
        if (sleep_req_i) begin
          if (pend) begin
            next_r.nop = 1'b1;
            ev[SWK_EV_NOP] = 1'b1;
            next_r.nopcnt = r.nopcnt + 8'h01;
            // no watchdog clear and no status change on this path
          end else begin
            next_r.st = SWK_EXEC;
            next_r.cnt = 3'h0;
            next_r.seen = 1'b0;
          end
        end
      end
      SWK_EXEC: begin
        next_r.cnt = r.cnt + 3'h1;
        next_r.seen = r.seen | pend;
        if (r.cnt == LAST) begin
          next_r.wdt_clr = 1'b1;
          next_r.to = 1'b1;
          next_r.pd = 1'b0;
          ev[SWK_EV_SLEEP] = 1'b1;
          if (r.seen | pend) begin
            next_r.st = SWK_WAKE;
          end else begin
            next_r.st = SWK_SLEEP;
          end
        end
      end
      SWK_SLEEP: begin
        if (pend) begin
          next_r.st = SWK_WAKE;
        end
      end
      SWK_WAKE: begin
        next_r.wake = 1'b1;
        ev[SWK_EV_WAKE] = 1'b1;
        next_r.vec = r.global_interrupt_enable;
        next_r.res = ~r.global_interrupt_enable;
        next_r.st = SWK_RUN;
      end
      default: begin
        next_r.st = SWK_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= SWK_CORE_RST;
    end else begin
      r <= next_r;
    end
  end

  // sleep requests outside the run state are ignored: the core is halted then
  assign sleep_o = (r.st == SWK_SLEEP);
  assign wdt_clear_o = r.wdt_clr;
  assign wake_o = r.wake;
  assign vector_o = r.vec;
  assign resume_o = r.res;
  assign nop_o = r.nop;

  always_comb begin
    rdata = '0;
    unmapped = 1'b0;
    case (paddr_i)
      SWK_OFF_CTRL: begin
        rdata[SWK_CTRL_GIE_BIT] = r.global_interrupt_enable;
      end
      SWK_OFF_STAT: begin
        rdata[SWK_STAT_TO_BIT] = r.to;
        rdata[SWK_STAT_PD_BIT] = r.pd;
        rdata[SWK_STAT_SLEEP_BIT] = sleep_o;
        rdata[SWK_STAT_PEND_BIT] = pend;
      end
      SWK_OFF_INT_STAT: begin
        rdata[SWK_EV_W-1:0] = istat;
      end
      SWK_OFF_INT_CLR: begin
        rdata = '0;
      end
      SWK_OFF_INT_EN: begin
        rdata[SWK_EV_W-1:0] = ien;
      end
      SWK_OFF_SRC: begin
        rdata[N_SRC-1:0] = hit;
      end
      SWK_OFF_NOPCNT: begin
        rdata[SWK_NOPCNT_W-1:0] = r.nopcnt;
      end
      default: begin
        unmapped = 1'b1;
      end
    endcase
  end

  assign prdata_o = acc ? rdata : '0;
  assign pready_o = 1'b1;
  assign pslverr_o = acc & unmapped;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_sleep_pending;
    r.st == SWK_RUN && sleep_req_i && pend;
  endsequence

  sequence s_sleep_clean;
    r.st == SWK_RUN && sleep_req_i && !pend;
  endsequence

  sequence s_exec_done;
    r.st == SWK_EXEC ##1 r.st != SWK_EXEC;
  endsequence

  AST_DOZE_WAKES_ON_PEND: assert property (
    r.st == SWK_SLEEP && pend |=> r.st == SWK_WAKE ##1 wake_o
  ) else $error("pending source did not wake the sleeping core");

  AST_PENDING_SLEEP_IS_NOP: assert property (
    s_sleep_pending |=> nop_o && r.st == SWK_RUN && !sleep_o
  ) else $error("sleep with pending source was not a no-op");

  AST_NOP_KEEPS_WATCHDOG: assert property (
    s_sleep_pending |=> !wdt_clear_o ##1 !wdt_clear_o
  ) else $error("no-op sleep cleared the watchdog");

  AST_NOP_KEEPS_STATUS: assert property (
    (s_sleep_pending and !wr_ctrl) |=> $stable(r.to) && $stable(r.pd)
  ) else $error("no-op sleep changed timeout or power-down bit");

  AST_EXEC_LENGTH: assert property (
    s_sleep_clean |=> (r.st == SWK_EXEC) [*4] ##1 r.st != SWK_EXEC
  ) else $error("sleep instruction did not take four cycles");

  AST_LATE_PEND_WAKES: assert property (
    r.st == SWK_EXEC && pend |-> ##[1:4] r.st == SWK_WAKE
  ) else $error("interrupt during sleep did not wake at once");

  AST_SLEEP_CLEARS_WATCHDOG: assert property (
    s_exec_done |-> wdt_clear_o ##1 !wdt_clear_o
  ) else $error("completed sleep did not pulse the watchdog clear");

  AST_SLEEP_SETS_STATUS: assert property (
    s_exec_done |-> r.to && !r.pd
  ) else $error("completed sleep left wrong timeout or power-down bit");

  AST_WAKE_VECTORS: assert property (
    r.st == SWK_WAKE && r.global_interrupt_enable |=> vector_o && !resume_o && r.st == SWK_RUN
  ) else $error("wake with interrupts on did not vector");

  AST_WAKE_INLINE: assert property (
    r.st == SWK_WAKE && !r.global_interrupt_enable |=> resume_o && !vector_o && r.st == SWK_RUN
  ) else $error("wake with interrupts off did not continue in line");

  // last instruction cycle, split by whether a source was seen in any cycle of the instruction
  sequence s_exec_seen;
    r.st == SWK_EXEC && r.cnt == LAST && (r.seen || pend);
  endsequence

  sequence s_exec_clean;
    r.st == SWK_EXEC && r.cnt == LAST && !r.seen && !pend;
  endsequence

  AST_WDT_ONLY_AFTER_EXEC: assert property (
    wdt_clear_o |-> $past(r.st) == SWK_EXEC
  ) else $error("watchdog cleared without a completed sleep");

  AST_NOP_QUIET: assert property (
    nop_o |-> !wake_o && !wdt_clear_o
  ) else $error("no-op sleep came with a wake or watchdog clear");

  AST_NOPCNT_STEP: assert property (
    nop_o |-> r.nopcnt == $past(r.nopcnt) + 8'h01
  ) else $error("no-op counter did not step on a no-op sleep");

  AST_NOPCNT_HOLD: assert property (
    !nop_o |-> $stable(r.nopcnt)
  ) else $error("no-op counter moved without a no-op sleep");

  AST_NOP_FLAGGED: assert property (
    nop_o |-> istat[SWK_EV_NOP]
  ) else $error("no-op sleep event not flagged");

  AST_PD_FALLS_ON_SLEEP: assert property (
    $fell(r.pd) |-> $past(r.st) == SWK_EXEC
  ) else $error("power-down bit cleared outside a completed sleep");

  AST_PD_RISES_ON_REARM: assert property (
    $rose(r.pd) |-> $past(wr_ctrl)
  ) else $error("power-down bit set without a rearm write");

  AST_SLEEP_ENTRY_STATUS: assert property (
    $rose(sleep_o) |-> wdt_clear_o && r.to && !r.pd
  ) else $error("sleep entered without watchdog clear and status update");

  AST_SEEN_NEVER_SLEEPS: assert property (
    r.st == SWK_EXEC && r.seen |=> !sleep_o
  ) else $error("sleep entered although a source was seen");

  AST_SEEN_WAKES: assert property (
    s_exec_seen |=> r.st == SWK_WAKE && wdt_clear_o ##1 wake_o
  ) else $error("source seen during sleep did not wake at once");

  AST_CLEAN_EXEC_SLEEPS: assert property (
    s_exec_clean |=> sleep_o && wdt_clear_o
  ) else $error("clean sleep did not enter sleep with watchdog clear");

  AST_REARM_LOSES: assert property (
    wr_ctrl && pwdata_i[SWK_CTRL_REARM_BIT] && r.st == SWK_EXEC && r.cnt == LAST |=> !r.pd
  ) else $error("rearm beat a completing sleep");

  AST_CLEAN_START: assert property (
    s_sleep_clean |=> r.st == SWK_EXEC && !nop_o && !wdt_clear_o
  ) else $error("clean sleep did not start executing");

  AST_EXEC_NO_NOP: assert property (
    r.st == SWK_EXEC |=> !nop_o
  ) else $error("executing sleep turned into a no-op");

  AST_WAKE_FROM_WAKE_STATE: assert property (
    wake_o |-> $past(r.st) == SWK_WAKE
  ) else $error("wake pulse outside the wake step");

  AST_WAKE_OUTCOME: assert property (
    wake_o |-> vector_o ^ resume_o
  ) else $error("wake without exactly one of vector or resume");

  AST_VEC_NEEDS_GIE: assert property (
    vector_o |-> $past(r.global_interrupt_enable)
  ) else $error("vector with interrupts off");

  AST_RES_NEEDS_NO_GIE: assert property (
    resume_o |-> !$past(r.global_interrupt_enable)
  ) else $error("in-line resume with interrupts on");

  AST_SLEEP_EVENT_FLAGGED: assert property (
    wdt_clear_o |-> istat[SWK_EV_SLEEP]
  ) else $error("completed sleep event not flagged");

  AST_WAKE_EVENT_FLAGGED: assert property (
    wake_o |-> istat[SWK_EV_WAKE]
  ) else $error("wake event not flagged");

  AST_DOZE_HOLDS: assert property (
    sleep_o && !pend |=> sleep_o
  ) else $error("left sleep without a pending source");

  AST_PEND_REQUIRED: assert property (
    $fell(sleep_o) |-> $past(pend)
  ) else $error("sleep ended although no source was pending");

endmodule : swk_ctrl

// File: design/swk_pkg.sv
// package of the sleep wake-up controller: map, fields, reset values, timing, types
// assumes a single 10 MHz clock and a core that pulses its sleep request once per sleep instruction in the run state
package swk_pkg;
  localparam int SWK_AW = 8;
  localparam int SWK_DW = 32;
  localparam logic [7:0] SWK_OFF_CTRL = 8'h00;
  localparam logic [7:0] SWK_OFF_STAT = 8'h04;
  localparam logic [7:0] SWK_OFF_INT_STAT = 8'h08;
  localparam logic [7:0] SWK_OFF_INT_CLR = 8'h0c;
  localparam logic [7:0] SWK_OFF_INT_EN = 8'h10;
  localparam logic [7:0] SWK_OFF_SRC = 8'h14;
  localparam logic [7:0] SWK_OFF_NOPCNT = 8'h18;
  localparam int SWK_CTRL_GIE_BIT = 0;
  localparam int SWK_CTRL_REARM_BIT = 1;
  localparam int SWK_STAT_TO_BIT = 0;
  localparam int SWK_STAT_PD_BIT = 1;
  localparam int SWK_STAT_SLEEP_BIT = 2;
  localparam int SWK_STAT_PEND_BIT = 3;
  localparam int SWK_EV_NOP = 0;
  localparam int SWK_EV_SLEEP = 1;
  localparam int SWK_EV_WAKE = 2;
  localparam int SWK_EV_W = 3;
  localparam int SWK_NOPCNT_W = 8;
  localparam logic SWK_RST_GIE = 1'b0;
  localparam logic SWK_RST_TO = 1'b1;
  localparam logic SWK_RST_PD = 1'b1;
  localparam logic [SWK_EV_W-1:0] SWK_RST_INT_EN = 3'h0;
  localparam longint SWK_CLK_HZ = 10000000;
  localparam longint SWK_INSN_NS = 400;
  localparam int SWK_INSN_CYC = int'((SWK_INSN_NS * SWK_CLK_HZ + 64'd999999999) / 64'd1000000000);
  typedef enum logic [1:0] {
    SWK_RUN,
    SWK_EXEC,
    SWK_SLEEP,
    SWK_WAKE
  } swk_state_t;
  typedef struct packed {
    swk_state_t st;
    logic [2:0] cnt;
    logic seen;
    logic global_interrupt_enable;
    logic to;
    logic pd;
    logic wdt_clr;
    logic wake;
    logic vec;
    logic res;
    logic nop;
    logic [SWK_NOPCNT_W-1:0] nopcnt;
  } swk_core_t;
  localparam swk_core_t SWK_CORE_RST = '{
    st: SWK_RUN,
    cnt: 3'h0,
    seen: 1'b0,
    global_interrupt_enable: SWK_RST_GIE,
    to: SWK_RST_TO,
    pd: SWK_RST_PD,
    wdt_clr: 1'b0,
    wake: 1'b0,
    vec: 1'b0,
    res: 1'b0,
    nop: 1'b0,
    nopcnt: 8'h00
  };
endpackage : swk_pkg

// File: design/swk_pend.sv
// pending detector: a source counts when its enable and its flag are both set
// assumes enables and flags come from logic on the same clock
`timescale 1ns/1ns
module swk_pend #(
  parameter int N = 8
) (
  input wire logic [N-1:0] int_en_i,
  input wire logic [N-1:0] int_flag_i,
  output logic [N-1:0] hit_o,
  output logic pend_o
);
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_src
      assign hit_o[i] = int_en_i[i] & int_flag_i[i];
    end
  endgenerate
  assign pend_o = |hit_o;
endmodule : swk_pend

// File: design/swk_irq.sv
// sticky event flags with enable mask and write-one-to-clear, one level interrupt
// assumes set and clear strobes are single cycles on the same clock
`timescale 1ns/1ns
module swk_irq
  import swk_pkg::*;
#(
  parameter int W = SWK_EV_W
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] set_i,
  input wire logic clr_wr_i,
  input wire logic en_wr_i,
  input wire logic [W-1:0] wdata_i,
  output logic [W-1:0] stat_o,
  output logic [W-1:0] en_o,
  output logic irq_o
);
  typedef struct packed {
    logic [W-1:0] stat;
    logic [W-1:0] en;
  } swk_irq_t;
  swk_irq_t r;
  swk_irq_t next_r;
  always_comb begin
    next_r = r;
    if (en_wr_i) begin
      next_r.en = wdata_i;
    end
    // set wins over a clear in the same cycle
    next_r.stat = (r.stat & ~(clr_wr_i ? wdata_i : '0)) | set_i;
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '{stat: '0, en: W'(SWK_RST_INT_EN)};
    end else begin
      r <= next_r;
    end
  end
  assign stat_o = r.stat;
  assign en_o = r.en;
  assign irq_o = |(r.stat & r.en);
endmodule : swk_irq

// File: testbench/swk_core_model.sv
// core side model: issues one sleep request per command, then waits for the outcome
// assumes the bench drives go_i for one cycle and done_i is nop, resume or vector
`timescale 1ns/1ns
module swk_core_model (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic done_i,
  output logic sleep_req_o,
  output logic busy_o
);
  // no second sleep until the first has come back, as the core would
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sleep_req_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      sleep_req_o <= go_i & ~busy_o;
      if (go_i & ~busy_o) begin
        busy_o <= 1'b1;
      end else if (done_i) begin
        busy_o <= 1'b0;
      end
    end
  end
endmodule : swk_core_model

// File: testbench/swk_ctrl_tb.sv
// self-checking bench of the sleep wake-up controller, apb master and core model
// assumes zero or more apb wait states; sources are driven straight by the bench
`timescale 1ns/1ns
module swk_ctrl_tb;
  import swk_pkg::*;
  logic mclk_i = 0;
  logic rst_i = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic go = 0;
  logic [SWK_AW-1:0] paddr = '0;
  logic [SWK_DW-1:0] pwdata = '0;
  logic [SWK_DW-1:0] prdata;
  logic [7:0] en = '0;
  logic [7:0] flag = '0;
  logic pready, pslverr, sleep_req, busy, sleep_o, wdt, wake, vec, res, nop, irq;
  int ev[5] = '{0, 0, 0, 0, 0};
  int slept = 0;
  int num_errors = 0;
  int checked = 0;
  logic [31:0] r;
  logic e;
  swk_ctrl swk_ctrl_i (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .sleep_req_i(sleep_req), .int_en_i(en),
    .int_flag_i(flag), .sleep_o(sleep_o), .wdt_clear_o(wdt), .wake_o(wake),
    .vector_o(vec), .resume_o(res), .nop_o(nop), .irq_o(irq));
  swk_core_model swk_core_model_i (.mclk_i(mclk_i), .rst_i(rst_i), .go_i(go),
    .done_i(nop | res | vec), .sleep_req_o(sleep_req), .busy_o(busy));
  initial begin
    forever #50 mclk_i = ~mclk_i;
  end
  // pulses last one cycle, so the mid-cycle edge sees each exactly once
  always @(negedge mclk_i) begin
    ev[0] += int'(wdt === 1'b1);
    ev[1] += int'(nop === 1'b1);
    ev[2] += int'(wake === 1'b1);
    ev[3] += int'(vec === 1'b1);
    ev[4] += int'(res === 1'b1);
    slept += int'(sleep_o === 1'b1);
  end
  task wrap_up;
    $display("counts: %0d checked, %0d num_errors", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    logic ok;
    @(posedge mclk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    ok = 1'b0;
    // answer taken at the very edge that samples pready high
    for (i = 0; i < 20 && ok !== 1'b1; i++) begin
      @(posedge mclk_i);
      r = prdata;
      e = pslverr;
      ok = pready;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (ok !== 1'b1) begin
      num_errors++;
      wrap_up;
    end
  endtask : apb
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, '0);
    chk(r, exp);
  endtask : rd
  task wait_ev(input int k, input int target);
    int i;
    for (i = 0; i < 40 && ev[k] < target; i++) begin
      @(negedge mclk_i);
    end
    @(posedge mclk_i);
    if (ev[k] < target) begin
      num_errors++;
      wrap_up;
    end
  endtask : wait_ev
  task sleep_cmd;
    @(posedge mclk_i);
    go <= 1'b1;
    @(posedge mclk_i);
    go <= 1'b0;
  endtask : sleep_cmd
  task chk_irq(input logic exp);
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
    chk({31'h0, irq}, {31'h0, exp});
    @(posedge mclk_i);
  endtask : chk_irq
  task t_reset;
    rd(SWK_OFF_STAT, 32'h3);
    rd(SWK_OFF_INT_EN, 32'h0);
    rd(8'h1c, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("test reset done");
  endtask : t_reset
  task t_nop;
    en <= 8'h81;
    flag <= 8'h80;
    sleep_cmd();
    wait_ev(1, 1);
    chk(ev[0], 0);
    chk(slept, 0);
    rd(SWK_OFF_STAT, 32'hb);
    rd(SWK_OFF_NOPCNT, 32'h1);
    flag <= 8'h00;
    $display("test no-op sleep done");
  endtask : t_nop
  task t_sleep;
    sleep_cmd();
    wait_ev(0, 1);
    rd(SWK_OFF_STAT, 32'h5);
    flag <= 8'h01;
    wait_ev(2, 1);
    wait_ev(4, 1);
    chk(ev[3], 0);
    rd(SWK_OFF_STAT, 32'h9);
    flag <= 8'h00;
    $display("test completed sleep done");
  endtask : t_sleep
  task t_during;
    apb(1'b1, SWK_OFF_CTRL, 32'h2);
    apb(1'b1, SWK_OFF_CTRL, 32'h1);
    rd(SWK_OFF_STAT, 32'h3);
    slept = 0;
    sleep_cmd();
    repeat (2) @(posedge mclk_i);
    flag <= 8'h01;
    wait_ev(0, 2);
    wait_ev(3, 1);
    chk(ev[2], 2);
    chk(slept, 0);
    chk(ev[4], 1);
    rd(SWK_OFF_STAT, 32'h9);
    flag <= 8'h00;
    $display("test flag during sleep done");
  endtask : t_during
  task t_irq;
    rd(SWK_OFF_INT_STAT, 32'h7);
    chk_irq(1'b0);
    apb(1'b1, SWK_OFF_INT_EN, 32'h2);
    chk_irq(1'b1);
    apb(1'b1, SWK_OFF_INT_CLR, 32'h2);
    chk_irq(1'b0);
    rd(SWK_OFF_INT_STAT, 32'h5);
    $display("test interrupt done");
  endtask : t_irq
  task t_rerun;
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(SWK_OFF_STAT, 32'h3);
    rd(SWK_OFF_NOPCNT, 32'h0);
    rd(SWK_OFF_INT_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test second reset done");
  endtask : t_rerun
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_reset();
    t_nop();
    t_sleep();
    t_during();
    t_irq();
    t_rerun();
    wrap_up();
  end
endmodule : swk_ctrl_tb
